/* core/sep_eeprom.sv */
// Serial EEPROM slave: link shifter, command decode, status and protection
//
// Summary of operation
// - Read data launched on falling edge, MSB first
// - Input bits captured on rising edge, MSB first
// - Select low starts; high deselects, output floats
// - Pause low, clock high or low: hold; output floats from the next falling edge
// - Hold ends cleanly, bit position kept
// - Deselect during hold abandons the command
// - No operation until select seen high first
// - Write needs latch, whole bytes, data, boundary
// - Deselect off a byte boundary discards write
// - Reads keep shifting data until deselect
// - Status bits 6..4 read as zero
// - Busy from accepted write until cycle ends
// - Write commands ignored while latch clear
// - Latch set by unlock, cleared by lock/write
// - Protect bits change only by status write
// - Protect codes select none, quarter, half, all
// - Lock bit clear: status always writable
// - Lock bit set, pin low: status write dropped
// - Locked state left only by pin high
// - Array of 1024 bytes, 32 pages of 32
// - Separate 32-byte id page, lockable read-only
// - Unknown opcode waits until deselect
// - Status write touches only lock and protect
// - Status readable any time, even busy
`timescale 1ns/1ps
module sep_eeprom
  import sep_pkg::*;
(
  // System clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Serial link
  input  wire logic       i_sclk,
  input  wire logic       i_chip_enable_n,
  input  wire logic       i_sdi,
  input  wire logic       i_pause_n,
  output logic            o_sdo,
  output logic            o_sdo_oe_n,
  // Write protect pin
  input  wire logic       i_protect_pin_n,
  // Observation
  output logic [7:0]      o_status
);

  // Storage; array and id page written only in the system domain, wbuf on the link clock
  logic [7:0]  mem     [0:ARRAY_BYTES-1];
  logic [7:0]  id_page [0:ID_BYTES-1];
  logic [7:0]  wbuf    [0:PAGE_BYTES-1];

  // System state
  logic        latch_set;
  logic        busy;
  logic [1:0]  prot;
  logic        lock_bit;
  logic        id_locked;
  logic [15:0] timer;
  logic [7:0]  job_op;
  logic        job_lock;
  logic [4:0]  job_page;
  logic [31:0] job_mask;
  logic        cs_m, cs_s, cs_d;
  logic        pause_m, pause_s;
  logic        prot_m, prot_s;
  logic        armed, frame_armed;

  // Link state
  logic        link_rst_n;
  logic        fresh;
  sep_phase_t  phase, cur_phase, next_phase;
  sep_frame_t  frame, cur_frame, next_frame;
  logic [7:0]  rx_shift, rx_byte, tx_shift, next_tx;
  logic [9:0]  rd_addr, next_rd_addr;
  logic        buf_we;
  logic [4:0]  buf_idx, buf_base;
  logic [7:0]  status_m, status_l;
  logic        armed_m, armed_l;

  function automatic logic [7:0] make_status(input logic lk, input logic [1:0] bp,
                                             input logic we, input logic bz);
    logic [7:0] s;
    s = 8'h00;
    s[STAT_LOCK]    = lk;
    s[STAT_PROT_HI] = bp[1];
    s[STAT_PROT_LO] = bp[0];
    s[STAT_LATCH]   = we;
    s[STAT_BUSY]    = bz;
    return s;
  endfunction : make_status

  function automatic logic is_write_type(input logic [7:0] op);
    return (op == OP_ARRAY_WRITE) || (op == OP_STATUS_WRITE) || (op == OP_ID_WRITE);
  endfunction : is_write_type

  function automatic logic in_protected(input logic [1:0] bp, input logic [9:0] a);
    logic r;
    case (bp)
      PROT_NONE:    r = 1'b0;
      PROT_QUARTER: r = (a >= BASE_QUARTER);
      PROT_HALF:    r = (a >= BASE_HALF);
      default:      r = 1'b1;
    endcase
    return r;
  endfunction : in_protected

  // Storage is only written while busy, and array reads are refused then (id page reads are not), so the
  // link may look at the array without a crossing.
  function automatic logic [7:0] read_byte(input logic [7:0] op, input logic [9:0] a);
    logic [7:0] d;
    case (op)
      OP_ARRAY_READ: d = mem[a];
      OP_ID_READ:    d = a[ID_LOCK_SEL_BIT] ? {7'h00, id_locked} : id_page[a[4:0]];
      default:       d = status_l;
    endcase
    return d;
  endfunction : read_byte

  // ---------------- Link domain ----------------

  // Deselect resets the shifter front end
  assign link_rst_n = i_reset_n & ~i_chip_enable_n;

  always_ff @(posedge i_sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
      fresh <= 1'b1;
    else if (i_pause_n)
      fresh <= 1'b0;
  end

  always_ff @(posedge i_sclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      status_m <= 8'h00;
      status_l <= 8'h00;
      armed_m  <= 1'b0;
      armed_l  <= 1'b0;
    end
    else
    begin
      status_m <= o_status;
      status_l <= status_m;
      armed_m  <= armed;
      armed_l  <= armed_m;
    end
  end

  always_comb
  begin
    cur_phase    = fresh ? PH_OPC : phase;
    cur_frame    = fresh ? '0 : frame;
    rx_byte      = {rx_shift[6:0], i_sdi};
    next_frame   = cur_frame;
    next_frame.bits = cur_frame.bits + 3'h1;
    next_phase   = cur_phase;
    next_tx      = {tx_shift[6:0], 1'b0};
    next_rd_addr = rd_addr;
    buf_we       = 1'b0;
    buf_base     = (cur_frame.opcode == OP_STATUS_WRITE) ? 5'h00 : cur_frame.addr[4:0];
    buf_idx      = buf_base + cur_frame.nbytes[4:0];
    if (cur_frame.bits == 3'h7)
    begin
      case (cur_phase)
        PH_OPC:
        begin
          next_frame.opcode = rx_byte;
          if (rx_byte == OP_STATUS_READ)
          begin
            next_phase = PH_OUT;
            next_tx    = status_l;
          end
          else if (rx_byte == OP_WRITE_UNLOCK || rx_byte == OP_WRITE_LOCK ||
                   rx_byte == OP_STATUS_WRITE)
            next_phase = PH_IN;
          else if (rx_byte == OP_ARRAY_READ && status_l[STAT_BUSY])
            next_phase = PH_WAIT;
          else if (rx_byte == OP_ARRAY_READ || rx_byte == OP_ARRAY_WRITE ||
                   rx_byte == OP_ID_READ || rx_byte == OP_ID_WRITE)
            next_phase = PH_ADDR_HI;
          else
          begin
            next_phase     = PH_WAIT;
            next_frame.bad = 1'b1;
          end
        end
        PH_ADDR_HI:
        begin
          next_frame.addr[15:8] = rx_byte;
          next_phase = PH_ADDR_LO;
        end
        PH_ADDR_LO:
        begin
          next_frame.addr[7:0] = rx_byte;
          if (is_write_type(cur_frame.opcode))
            next_phase = PH_IN;
          else
          begin
            next_phase   = PH_OUT;
            next_tx      = read_byte(cur_frame.opcode, {cur_frame.addr[9:8], rx_byte});
            next_rd_addr = {cur_frame.addr[9:8], rx_byte} + 10'h001;
          end
        end
        PH_IN:
        begin
          if (cur_frame.nbytes != 6'h3f)
            next_frame.nbytes = cur_frame.nbytes + 6'h01;
          // Buffer frozen while a committed page is being written
          if (!status_l[STAT_BUSY])
          begin
            buf_we = 1'b1;
            next_frame.wmask[buf_idx] = 1'b1;
          end
        end
        PH_OUT:
        begin
          next_tx      = read_byte(cur_frame.opcode, rd_addr);
          next_rd_addr = rd_addr + 10'h001;
        end
        default: next_phase = PH_WAIT;
      endcase
    end
  end

  // Hold freezes every command record register, so position survives the pause
  always_ff @(posedge i_sclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      phase    <= PH_OPC;
      frame    <= '0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      rd_addr  <= 10'h000;
    end
    // Edges while deselected, as on a mode change, must not touch the record
    else if (i_pause_n && !i_chip_enable_n)
    begin
      phase    <= next_phase;
      frame    <= next_frame;
      rx_shift <= rx_byte;
      tx_shift <= next_tx;
      rd_addr  <= next_rd_addr;
    end
  end

  always_ff @(posedge i_sclk)
  begin
    if (i_pause_n && buf_we)
      wbuf[buf_idx] <= rx_byte;
  end

  always_ff @(negedge i_sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      o_sdo      <= 1'b0;
      o_sdo_oe_n <= 1'b1;
    end
    else
    begin
      o_sdo      <= tx_shift[7];
      o_sdo_oe_n <= !(i_pause_n && !fresh && armed_l && phase == PH_OUT);
    end
  end

  a_wait_sticks: assert property (@(posedge i_sclk) disable iff (!link_rst_n)
    (!fresh && phase == PH_WAIT && i_pause_n) |=> (phase == PH_WAIT))
    else $error("left wait state before deselect");

  a_hold_freezes: assert property (@(posedge i_sclk) disable iff (!link_rst_n)
    (!fresh && !i_pause_n) |=> $stable(frame) && $stable(phase))
    else $error("link state moved during hold");

  // ---------------- System domain ----------------

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cs_m    <= 1'b0;
      cs_s    <= 1'b0;
      cs_d    <= 1'b0;
      pause_m <= 1'b1;
      pause_s <= 1'b1;
      prot_m  <= 1'b1;
      prot_s  <= 1'b1;
    end
    else
    begin
      cs_m    <= i_chip_enable_n;
      cs_s    <= cs_m;
      cs_d    <= cs_s;
      pause_m <= i_pause_n;
      pause_s <= pause_m;
      prot_m  <= i_protect_pin_n;
      prot_s  <= prot_m;
    end
  end

  logic frame_end, frame_start, whole, writable, accept;

  assign frame_end   = cs_s & ~cs_d;
  assign frame_start = ~cs_s & cs_d;

  // Select held low through reset never counts as a frame
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      armed       <= 1'b0;
      frame_armed <= 1'b0;
    end
    else
    begin
      if (cs_s)
        armed <= 1'b1;
      if (frame_start)
        frame_armed <= armed;
    end
  end

  // Frame record is stable here: link edges while deselected do not update it
  always_comb
  begin
    whole    = (frame.bits == 3'h0) && !frame.bad && pause_s;
    writable = !lock_bit || prot_s;
    accept   = 1'b0;
    if (frame_end && frame_armed && latch_set && whole && !busy &&
        frame.nbytes != 6'h00 && is_write_type(frame.opcode))
    begin
      case (frame.opcode)
        OP_STATUS_WRITE: accept = writable;
        OP_ARRAY_WRITE:  accept = !in_protected(prot, frame.addr[9:0]);
        default:         accept = !id_locked && prot != PROT_ALL;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      latch_set <= 1'b0;
      busy      <= 1'b0;
      prot      <= PROT_RST;
      lock_bit  <= LOCK_RST;
      id_locked <= ID_LOCK_RST;
      timer     <= 16'h0000;
      job_op    <= 8'h00;
      job_lock  <= 1'b0;
      job_page  <= 5'h00;
      job_mask  <= 32'h0000_0000;
    end
    else
    begin
      if (busy)
      begin
        timer <= timer - 16'h0001;
        if (timer == 16'h0000)
        begin
          busy      <= 1'b0;
          latch_set <= 1'b0;
          if (job_op == OP_STATUS_WRITE)
          begin
            lock_bit <= wbuf[0][STAT_LOCK];
            prot     <= {wbuf[0][STAT_PROT_HI], wbuf[0][STAT_PROT_LO]};
          end
          else if (job_lock)
            id_locked <= 1'b1;
        end
      end
      if (frame_end && frame_armed && whole && frame.nbytes == 6'h00)
      begin
        if (frame.opcode == OP_WRITE_LOCK)
          latch_set <= 1'b0;
        if (frame.opcode == OP_WRITE_UNLOCK)
          latch_set <= 1'b1;
      end
      if (accept)
      begin
        busy     <= 1'b1;
        timer    <= 16'(TW_CYCLES - 1);
        job_op   <= frame.opcode;
        job_lock <= (frame.opcode == OP_ID_WRITE) && frame.addr[ID_LOCK_SEL_BIT];
        job_page <= frame.addr[9:5];
        job_mask <= frame.wmask;
      end
    end
  end

  // Page is committed one byte per cycle in the last cycles of the write
  always_ff @(posedge i_clk)
  begin
    if (busy && timer < 16'(PAGE_BYTES) && job_mask[timer[4:0]])
    begin
      if (job_op == OP_ARRAY_WRITE)
        mem[{job_page, timer[4:0]}] <= wbuf[timer[4:0]];
      else if (job_op == OP_ID_WRITE && !job_lock)
        id_page[timer[4:0]] <= wbuf[timer[4:0]];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_status <= 8'h00;
    else
      o_status <= make_status(lock_bit, prot, latch_set, busy);
  end

  // ---------------- Checks ----------------

  sequence s_accept;
    accept;
  endsequence

  sequence s_cycle;
    busy [*8];
  endsequence

  a_busy_holds: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    s_accept |=> s_cycle)
    else $error("busy did not hold through write cycle");

  a_busy_ends: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $fell(busy) |-> ($past(timer) == 16'h0000))
    else $error("busy dropped before cycle count ran out");

  // An unlock ending in the same cycle wins over the clear
  a_latch_cleared: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $fell(busy) && !$past(frame_end && frame.opcode == OP_WRITE_UNLOCK) |-> !latch_set)
    else $error("latch still set after write cycle");

  a_needs_latch: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    accept |-> latch_set)
    else $error("write accepted with latch clear");

  a_locked_status: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (frame_end && frame.opcode == OP_STATUS_WRITE && lock_bit && !prot_s) |-> !accept)
    else $error("status write taken while locked");

  a_partial_drop: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (frame_end && frame.bits != 3'h0) |-> !accept)
    else $error("write accepted off a byte boundary");

  a_unarmed_quiet: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (frame_end && !frame_armed) |=> $stable(latch_set) && !busy)
    else $error("frame acted on before first select edge");

  a_status_image: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ##1 (o_status == {$past(lock_bit), 3'h0, $past(prot), $past(latch_set), $past(busy)}))
    else $error("status image does not match state");

  a_protect_only: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $changed(prot) |-> $past(busy) && $past(job_op) == OP_STATUS_WRITE)
    else $error("protect bits changed outside a status write");

endmodule : sep_eeprom

/* pkg/sep_pkg.sv */
// Constants and types shared by the serial EEPROM slave front end
package sep_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_WRITE_NS    = 5000;
  localparam int TW_CYCLES     = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Storage geometry
  localparam int ARRAY_BYTES = 1024;
  localparam int PAGE_BYTES  = 32;
  localparam int ID_BYTES    = 32;

  // Opcodes
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_WRITE_LOCK   = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;
  localparam logic [7:0] OP_ID_READ      = 8'h83;
  localparam logic [7:0] OP_ID_WRITE     = 8'h82;

  // Address bit that turns an id page access into the lock-state access
  localparam int ID_LOCK_SEL_BIT = 7;

  // Status register fields
  localparam int STAT_BUSY    = 0;
  localparam int STAT_LATCH   = 1;
  localparam int STAT_PROT_LO = 2;
  localparam int STAT_PROT_HI = 3;
  localparam int STAT_LOCK    = 7;

  // Reset values (delivery state of the non-volatile bits)
  localparam logic [1:0] PROT_RST    = 2'h0;
  localparam logic       LOCK_RST    = 1'h0;
  localparam logic       ID_LOCK_RST = 1'h0;

  // Protect encodings and region bases
  localparam logic [1:0] PROT_NONE    = 2'h0;
  localparam logic [1:0] PROT_QUARTER = 2'h1;
  localparam logic [1:0] PROT_HALF    = 2'h2;
  localparam logic [1:0] PROT_ALL     = 2'h3;
  localparam logic [9:0] BASE_QUARTER = 10'h300;
  localparam logic [9:0] BASE_HALF    = 10'h200;

  // Link-side command phase
  typedef enum logic [2:0] {
    PH_OPC     = 3'b000,
    PH_ADDR_HI = 3'b001,
    PH_ADDR_LO = 3'b010,
    PH_IN      = 3'b011,
    PH_OUT     = 3'b100,
    PH_WAIT    = 3'b101
  } sep_phase_t;

  // Record of one select frame, left standing after deselect
  typedef struct packed {
    logic [7:0]  opcode;
    logic [15:0] addr;
    logic [5:0]  nbytes;
    logic [2:0]  bits;
    logic        bad;
    logic [31:0] wmask;
  } sep_frame_t;

endpackage : sep_pkg

/* test/sep_eeprom_bench.sv */
// Self-checking bench for the serial EEPROM slave front end
`timescale 1ns/1ps
module sep_eeprom_bench;
  import sep_pkg::*;
  logic       i_clk           = 1'b0;
  logic       i_reset_n       = 1'b0;
  logic       i_protect_pin_n = 1'b1;
  logic       sclk, cs_n, sdi, pause_n, sdo, sdo_oe_n;
  logic [7:0] status;
  logic [7:0] r, r2;
  logic       b, e;
  logic [9:0] addrs [3] = '{10'h000, 10'h200, 10'h300};
  int         n_fail    = 0;
  int         cmp_count = 0;

  initial
  begin
    forever #5 i_clk = ~i_clk;
  end

  sep_eeprom u_dut (
    .i_clk           (i_clk),
    .i_reset_n       (i_reset_n),
    .i_sclk          (sclk),
    .i_chip_enable_n (cs_n),
    .i_sdi           (sdi),
    .i_pause_n       (pause_n),
    .o_sdo           (sdo),
    .o_sdo_oe_n      (sdo_oe_n),
    .i_protect_pin_n (i_protect_pin_n),
    .o_status        (status)
  );

  sep_master_model u_master (
    .o_sclk          (sclk),
    .o_chip_enable_n (cs_n),
    .o_sdi           (sdi),
    .o_pause_n       (pause_n),
    .i_sdo           (sdo),
    .i_sdo_oe_n      (sdo_oe_n)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  task automatic send(input int n, input logic [31:0] v);
    for (int i = n - 1; i >= 0; i--)
      u_master.xbits(8, v[8*i +: 8], r);
  endtask : send

  task automatic frame(input int n, input logic [31:0] v);
    u_master.sel();
    send(n, v);
    u_master.desel();
  endtask : frame

  task automatic unlock();
    frame(1, {24'h0, OP_WRITE_UNLOCK});
  endtask : unlock

  task automatic wstat(input logic [7:0] d);
    unlock();
    frame(2, {16'h0, OP_STATUS_WRITE, d});
  endtask : wstat

  task automatic rd(input logic [7:0] op, input logic [15:0] a, output logic [7:0] d);
    u_master.sel();
    send(3, {8'h0, op, a});
    u_master.xbits(8, 8'h00, d);
    u_master.desel();
  endtask : rd

  task automatic busy_after(output logic bz);
    repeat (8) @(negedge i_clk);
    bz = status[0];
  endtask : busy_after

  // Bounded poll; a stuck busy ends the run
  task automatic wait_ready();
    int k = 0;
    while (status[0] !== 1'b0 && k < 2000)
    begin
      @(negedge i_clk);
      k++;
    end
    if (k == 2000)
    begin
      n_fail++;
      $display("CHECK FAILED ready expected 0 seen 1");
      final_report();
    end
  endtask : wait_ready

  initial
  begin
    #900000;
    n_fail++;
    $display("CHECK FAILED run time expected end seen hang");
    final_report();
  end

  initial
  begin
    repeat (3) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (4) @(negedge i_clk);
    #3;
    check("status after reset", status, 8'h00);
    unlock();
    check("latch set", status, 8'h02);
    frame(1, {24'h0, OP_WRITE_LOCK});
    check("latch cleared", status, 8'h00);
    frame(2, {16'h0, OP_STATUS_WRITE, 8'h0c});
    busy_after(b);
    check("write without latch", {7'h0, b}, 8'h00);
    for (int p = 0; p < 4; p++)
    begin
      wstat({4'h0, p[1:0], 2'h0});
      wait_ready();
      check("protect code", status, {4'h0, p[1:0], 2'h0});
      for (int j = 0; j < 3; j++)
      begin
        e = (p == 0) || (p == 1 && addrs[j] < 10'h300) || (p == 2 && addrs[j] < 10'h200);
        unlock();
        frame(4, {OP_ARRAY_WRITE, 6'h00, addrs[j], 8'h11});
        busy_after(b);
        check("protect range", {7'h0, b}, {7'h0, e});
        wait_ready();
      end
    end
    wstat(8'h73);
    wait_ready();
    check("fixed bits kept", status, 8'h00);
    unlock();
    u_master.sel();
    send(3, {8'h0, OP_ARRAY_WRITE, 16'h03fe});
    u_master.xbits(4, 8'h0a, r);
    u_master.gap(b);
    u_master.xbits(4, 8'h05, r);
    u_master.xbits(8, 8'h5a, r);
    u_master.desel();
    busy_after(b);
    check("busy after write", {7'h0, b}, 8'h01);
    wait_ready();
    check("latch after cycle", status, 8'h00);
    u_master.mode3 = 1'b1;
    u_master.sel();
    send(3, {8'h0, OP_ARRAY_READ, 16'h03fe});
    u_master.xbits(8, 8'h00, r);
    check("read first byte", r, 8'ha5);
    u_master.gap(b);
    check("float in hold", {7'h0, b}, 8'h01);
    u_master.xbits(8, 8'h00, r);
    check("read after hold", r, 8'h5a);
    u_master.xbits(8, 8'h00, r);
    check("read wraps", r, 8'h11);
    u_master.desel();
    u_master.mode3 = 1'b0;
    check("float deselected", {7'h0, sdo_oe_n}, 8'h01);
    unlock();
    frame(4, {OP_ARRAY_WRITE, 16'h0010, 8'h3c});
    u_master.sel();
    send(1, {24'h0, OP_STATUS_READ});
    u_master.xbits(8, 8'h00, r);
    u_master.xbits(8, 8'h00, r2);
    u_master.desel();
    check("status while busy", r, 8'h03);
    check("status repeats", r2, 8'h03);
    wait_ready();
    unlock();
    u_master.sel();
    send(4, {OP_ARRAY_WRITE, 16'h0010, 8'h77});
    u_master.xbits(3, 8'h05, r);
    u_master.desel();
    busy_after(b);
    check("partial byte", {7'h0, b}, 8'h00);
    frame(3, {8'h0, OP_ARRAY_WRITE, 16'h0010});
    busy_after(b);
    check("no data byte", {7'h0, b}, 8'h00);
    u_master.sel();
    send(4, {OP_ARRAY_WRITE, 16'h0010, 8'h99});
    u_master.abort();
    busy_after(b);
    check("abort in hold", {7'h0, b}, 8'h00);
    rd(OP_ARRAY_READ, 16'h0010, r);
    check("memory untouched", r, 8'h3c);
    u_master.sel();
    send(2, {16'h0, 8'hff, 8'h03});
    u_master.xbits(8, 8'h00, r);
    u_master.desel();
    check("unknown opcode quiet", {7'h0, u_master.oe_seen}, 8'h00);
    unlock();
    frame(4, {OP_ID_WRITE, 16'h0005, 8'h5c});
    wait_ready();
    rd(OP_ID_READ, 16'h0005, r);
    check("id page", r, 8'h5c);
    i_protect_pin_n = 1'b0;
    wstat(8'h84);
    wait_ready();
    check("unlocked write", status, 8'h84);
    wstat(8'h00);
    busy_after(b);
    check("locked refuse", {7'h0, b}, 8'h00);
    check("locked frozen", status & 8'hfc, 8'h84);
    i_protect_pin_n = 1'b1;
    repeat (4) @(negedge i_clk);
    wstat(8'h00);
    wait_ready();
    check("pin high unlocks", status, 8'h00);
    unlock();
    frame(4, {OP_ID_WRITE, 16'h0080, 8'h02});
    wait_ready();
    rd(OP_ID_READ, 16'h0080, r);
    check("id lock state", r, 8'h01);
    unlock();
    frame(4, {OP_ID_WRITE, 16'h0005, 8'ha0});
    busy_after(b);
    check("id page read-only", {7'h0, b}, 8'h00);
    // Select held low through a reset: that frame must not count
    u_master.sel();
    i_reset_n = 1'b0;
    repeat (3) @(negedge i_clk);
    i_reset_n = 1'b1;
    send(1, {24'h0, OP_WRITE_UNLOCK});
    u_master.desel();
    check("select low at reset", status, 8'h00);
    unlock();
    check("latch after first edge", status, 8'h02);
    final_report();
  end
endmodule : sep_eeprom_bench

/* test/sep_master_model.sv */
// Behavioural serial bus master driving the slave's link pins
`timescale 1ns/1ps
module sep_master_model (
  // Serial link toward the slave
  output logic      o_sclk,
  output logic      o_chip_enable_n,
  output logic      o_sdi,
  output logic      o_pause_n,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe_n
);
  localparam int HALF = 16;
  logic mode3   = 1'b0;
  logic oe_seen = 1'b0;

  initial
  begin
    o_sclk          = 1'b0;
    o_chip_enable_n = 1'b1;
    o_sdi           = 1'b0;
    o_pause_n       = 1'b1;
  end

  task automatic sel();
    o_sclk = mode3;
    #HALF;
    o_chip_enable_n = 1'b0;
    oe_seen = 1'b0;
    #HALF;
  endtask : sel

  // Floating output reads back as unknown so it can never match
  task automatic xbit(input logic b, output logic r);
    o_sclk = 1'b0;
    o_sdi  = b;
    #HALF;
    o_sclk = 1'b1;
    r = (i_sdo_oe_n === 1'b0) ? i_sdo : 1'bx;
    if (i_sdo_oe_n === 1'b0)
      oe_seen = 1'b1;
    #HALF;
  endtask : xbit

  task automatic xbits(input int n, input logic [7:0] v, output logic [7:0] r);
    r = 8'h00;
    for (int i = n - 1; i >= 0; i--)
      xbit(v[i], r[i]);
  endtask : xbits

  task automatic desel();
    if (!mode3)
      o_sclk = 1'b0;
    #HALF;
    o_chip_enable_n = 1'b1;
    o_sdi = ~o_sdi;
    #60;
  endtask : desel

  // Pause with clock high, then junk clocks that must be ignored
  task automatic gap(output logic oe_n);
    o_pause_n = 1'b0;
    #HALF;
    repeat (3)
    begin
      o_sclk = 1'b0;
      o_sdi  = ~o_sdi;
      #HALF;
      o_sclk = 1'b1;
      #HALF;
    end
    oe_n = i_sdo_oe_n;
    o_pause_n = 1'b1;
    #HALF;
  endtask : gap

  task automatic abort();
    o_pause_n = 1'b0;
    #HALF;
    o_sclk = 1'b0;
    #HALF;
    o_chip_enable_n = 1'b1;
    #HALF;
    o_pause_n = 1'b1;
    o_sclk = mode3;
    #60;
  endtask : abort
endmodule : sep_master_model
